//--- design/csc_top.v
`timescale 1ns/100ps
`include "csc_map.vh"
module csc_top #(
    parameter               UPD_CYC   = `CSC_UPD_MS * `CSC_CLK_KHZ,
    parameter        [3:0]  PMAX_DIST = 4'h4,
    parameter        [3:0]  PMAX_VEL  = 4'h3,
    parameter        [3:0]  PMAX_ANG  = 4'h3,
    parameter        [3:0]  PMAX_STR  = 4'h3,
    parameter signed [39:0] KT        = 40'sh5d,
    parameter signed [39:0] KP        = 40'sh24,
    parameter signed [39:0] KH        = 40'sh1
) (
    // Clock and reset
    input  wire               sys_clk,
    input  wire               rst_n,
    // Keypad and entry
    input  wire               key_evt,
    input  wire        [2:0]  key_id,
    input  wire               entry_vld,
    input  wire signed [15:0] entry_val,
    input  wire               hi_err,
    // Measurement path
    input  wire        [1:0]  meas_kind,
    input  wire signed [31:0] meas_in,
    input  wire               meas_vld,
    output reg  signed [31:0] meas_out,
    output reg                meas_out_vld,
    // Air sensor pins
    input  wire               sens_present,
    input  wire        [2:0]  sens_fault,
    input  wire        [15:0] air_temp,
    input  wire        [16:0] air_pres,
    input  wire        [7:0]  air_hum,
    // Unit switch pin
    input  wire               unit_imp,
    // Display
    output reg         [3:0]  disp_code,
    output reg  signed [31:0] disp_val,
    output reg         [2:0]  disp_frac,
    // Settings state
    output reg         [13:0] comp_setting,
    output reg         [3:0]  prec_places,
    output reg                smooth_on,
    output reg  signed [15:0] exp_coef
);
    // Reset release
    reg rst_q1_r;
    reg rst_q2_r;
    wire rst_i_n = rst_q2_r;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1_r <= 1'b0;
            rst_q2_r <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_q2_r <= rst_q1_r;
        end
    end

    // Pin synchronisers; sensor words may tear for one sample
    reg  [45:0] pin_s1_r;
    reg  [45:0] pin_s2_r;
    wire [45:0] pin_raw = {sens_present, sens_fault, unit_imp, air_temp, air_pres, air_hum};
    wire        sens_on = pin_s2_r[45];
    wire [2:0]  flt     = pin_s2_r[44:42];
    wire        imp     = pin_s2_r[41];
    wire [15:0] a_t     = pin_s2_r[40:25];
    wire [16:0] a_p     = pin_s2_r[24:8];
    wire [7:0]  a_h     = pin_s2_r[7:0];

    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pin_s1_r <= 46'h0;
            pin_s2_r <= 46'h0;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Linear air model around standard conditions
    function [13:0] sens_calc;
        input [15:0] t;
        input [16:0] p;
        input [7:0]  h;
        reg signed [39:0] acc;
        begin
            acc = $signed({26'h0, `CSC_COMP_DEF})
                + (($signed({24'h0, t}) - $signed({24'h0, `CSC_T_STD})) * KT) / 40'sh64
                - (($signed({23'h0, p}) - $signed({23'h0, `CSC_P_STD})) * KP) / 40'sh64
                + ($signed({32'h0, h}) - $signed({32'h0, `CSC_H_STD})) * KH;
            if (acc < 40'sh0)
                acc = 40'sh0;
            else if (acc > $signed({24'h0, `CSC_COMP_MAX}))
                acc = $signed({24'h0, `CSC_COMP_MAX});
            sens_calc = acc[13:0];
        end
    endfunction

    // Next valid air reading after cur, else back to mode
    function [3:0] next_air;
        input [3:0] cur;
        input [2:0] bad;
        input       on;
        begin
            next_air = `CSC_D_MEAS;
            if (on) begin
                if (cur < `CSC_D_TEMP && !bad[0])
                    next_air = `CSC_D_TEMP;
                else if (cur < `CSC_D_PRES && !bad[1])
                    next_air = `CSC_D_PRES;
                else if (cur < `CSC_D_HUM && !bad[2])
                    next_air = `CSC_D_HUM;
            end
        end
    endfunction

    function is_air;
        input [3:0] c;
        begin
            is_air = (c == `CSC_D_TEMP) || (c == `CSC_D_PRES) || (c == `CSC_D_HUM);
        end
    endfunction

    function [3:0] pmax;
        input [1:0] k;
        begin
            case (k)
                `CSC_MK_DIST: pmax = PMAX_DIST;
                `CSC_MK_VEL:  pmax = PMAX_VEL;
                `CSC_MK_ANG:  pmax = PMAX_ANG;
                default:      pmax = PMAX_STR;
            endcase
        end
    endfunction

    // Settings and display state
    reg         [3:0]  disp_r, disp_nxt;
    reg         [13:0] man_r, man_nxt;
    reg         [13:0] sens_r;
    reg         [3:0]  prec_r, prec_nxt;
    reg                smooth_r, smooth_nxt;
    reg  signed [15:0] exp_r, exp_nxt;
    reg         [2:0]  err_key_r, err_key_nxt;
    reg  signed [15:0] lim_r, lim_nxt;
    reg                cerr_r, cerr_nxt;
    reg         [3:0]  last_air_r, last_air_nxt;
    reg         [2:0]  flt_q_r;
    reg         [31:0] tmr_r;

    wire [13:0] comp_eff = sens_on ? sens_r : man_r;
    wire        flt_rise = |(flt & ~flt_q_r);
    wire        err_disp = (disp_r == `CSC_D_OVER) || (disp_r == `CSC_D_UNDER);
    wire        same_key = (key_id == err_key_r);
    wire        use_lim  = key_evt && !entry_vld && (disp_r == `CSC_D_LIMIT) && same_key;
    wire        eff_set  = entry_vld || use_lim;
    wire signed [15:0] eff_val = use_lim ? lim_r : entry_val;
    wire        neg      = eff_val[15];
    wire signed [15:0] mag = neg ? -eff_val : eff_val;
    wire signed [15:0] p_lo = {15'h0, imp};
    wire signed [15:0] p_hi = {12'h0, pmax(meas_kind)} + {15'h0, imp};

    // Shared range check, bounds by key
    reg  signed [15:0] chk_val;
    reg  signed [15:0] chk_lo;
    reg  signed [15:0] chk_hi;
    wire               too_big;
    wire               too_small;

    always @* begin
        chk_val = eff_val;
        chk_lo  = 16'h0;
        chk_hi  = `CSC_COMP_MAX;
        if (key_id == `CSC_KEY_PREC) begin
            chk_val = mag;
            chk_lo  = p_lo;
            chk_hi  = p_hi;
        end else if (key_id == `CSC_KEY_EXP) begin
            chk_lo  = `CSC_EXP_MIN;
            chk_hi  = `CSC_EXP_MAX;
        end
    end

    csc_limit #(.W(16)) u_limit (.val(chk_val), .lo(chk_lo), .hi(chk_hi), .too_big(too_big),
        .too_small(too_small));

    // Key handling; keypad delivers one pulse per press
    always @* begin
        disp_nxt     = disp_r;
        man_nxt      = man_r;
        prec_nxt     = prec_r;
        smooth_nxt   = smooth_r;
        exp_nxt      = exp_r;
        err_key_nxt  = err_key_r;
        lim_nxt      = lim_r;
        cerr_nxt     = cerr_r;
        last_air_nxt = last_air_r;
        if (key_evt) begin
            case (key_id)
                `CSC_KEY_COMP: begin
                    if (eff_set) begin
                        if (sens_on) begin
                            disp_nxt = `CSC_D_FACT;
                        end else if (too_big && eff_val != `CSC_COMP_ONE) begin
                            disp_nxt    = `CSC_D_OVER;
                            err_key_nxt = key_id;
                            lim_nxt     = `CSC_COMP_MAX;
                        end else if (too_small) begin
                            disp_nxt    = `CSC_D_UNDER;
                            err_key_nxt = key_id;
                            lim_nxt     = 16'h0;
                        end else begin
                            man_nxt  = eff_val[13:0];
                            disp_nxt = `CSC_D_FACT;
                        end
                    end else if (err_disp && same_key) begin
                        disp_nxt = `CSC_D_LIMIT;
                    end else if (is_air(disp_r)) begin
                        disp_nxt = next_air(disp_r, flt, sens_on);
                    end else if (disp_r == `CSC_D_FACT || disp_r == `CSC_D_CERR) begin
                        disp_nxt = next_air(`CSC_D_FACT, flt, sens_on);
                    end else if (cerr_r) begin
                        disp_nxt = `CSC_D_CERR;
                        cerr_nxt = 1'b0;
                    end else if (last_air_r != `CSC_D_MEAS) begin
                        disp_nxt = next_air(last_air_r - 4'h1, flt, sens_on);
                    end else begin
                        disp_nxt = `CSC_D_FACT;
                    end
                    if (is_air(disp_nxt))
                        last_air_nxt = disp_nxt;
                    else if (disp_nxt == `CSC_D_MEAS)
                        last_air_nxt = `CSC_D_MEAS;
                end
                `CSC_KEY_PREC: begin
                    if (eff_set) begin
                        err_key_nxt = key_id;
                        if (too_big) begin
                            disp_nxt = `CSC_D_OVER;
                            lim_nxt  = neg ? -p_hi : p_hi;
                        end else if (too_small) begin
                            disp_nxt = `CSC_D_UNDER;
                            lim_nxt  = neg ? -p_lo : p_lo;
                        end else begin
                            // Stored in metric places
                            prec_nxt   = mag[3:0] - {3'h0, imp};
                            smooth_nxt = !neg;
                            disp_nxt   = `CSC_D_PREC;
                        end
                    end else if (err_disp && same_key) begin
                        disp_nxt = `CSC_D_LIMIT;
                    end else if (disp_r == `CSC_D_PREC) begin
                        disp_nxt = `CSC_D_MEAS;
                    end else begin
                        disp_nxt = `CSC_D_PREC;
                    end
                end
                `CSC_KEY_EXP: begin
                    if (eff_set) begin
                        err_key_nxt = key_id;
                        if (too_big) begin
                            disp_nxt = `CSC_D_OVER;
                            lim_nxt  = `CSC_EXP_MAX;
                        end else if (too_small) begin
                            disp_nxt = `CSC_D_UNDER;
                            lim_nxt  = `CSC_EXP_MIN;
                        end else begin
                            exp_nxt  = eff_val;
                            disp_nxt = `CSC_D_EXPC;
                        end
                    end else if (err_disp && same_key) begin
                        disp_nxt = `CSC_D_LIMIT;
                    end else if (disp_r == `CSC_D_EXPC) begin
                        disp_nxt = `CSC_D_MEAS;
                    end else begin
                        disp_nxt = `CSC_D_EXPC;
                    end
                end
                default: begin
                    // Any other function leaves the setup display
                    disp_nxt = `CSC_D_MEAS;
                end
            endcase
        end
        // Placed last so a new fault beats a same-cycle clear
        if (flt_rise && sens_on) begin
            cerr_nxt = 1'b1;
            if (!hi_err)
                disp_nxt = `CSC_D_SFLT;
        end
    end

    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            disp_r     <= `CSC_D_MEAS;
            man_r      <= `CSC_COMP_DEF;
            sens_r     <= `CSC_COMP_DEF;
            prec_r     <= `CSC_PREC_DEF;
            smooth_r   <= `CSC_SMOOTH_DEF;
            exp_r      <= `CSC_EXP_DEF;
            err_key_r  <= 3'h0;
            lim_r      <= 16'h0;
            cerr_r     <= 1'b0;
            last_air_r <= `CSC_D_MEAS;
            flt_q_r    <= 3'h0;
            tmr_r      <= 32'h0;
        end else begin
            disp_r     <= disp_nxt;
            man_r      <= man_nxt;
            prec_r     <= prec_nxt;
            smooth_r   <= smooth_nxt;
            exp_r      <= exp_nxt;
            err_key_r  <= err_key_nxt;
            lim_r      <= lim_nxt;
            cerr_r     <= cerr_nxt;
            last_air_r <= last_air_nxt;
            flt_q_r    <= flt;
            // Faulty readings freeze the last good factor
            if (tmr_r == UPD_CYC - 1) begin
                tmr_r <= 32'h0;
                if (sens_on && flt == 3'h0)
                    sens_r <= sens_calc(a_t, a_p, a_h);
            end else begin
                tmr_r <= tmr_r + 32'h1;
            end
        end
    end

    // Compensated and smoothed measurement
    wire signed [31:0] scaled;
    wire               scaled_vld;
    wire               comp_kind = (meas_kind == `CSC_MK_DIST) || (meas_kind == `CSC_MK_VEL);
    wire signed [32:0] avg_sum = {meas_out[31], meas_out} + {scaled[31], scaled};

    csc_scale u_scale (.sys_clk(sys_clk), .rst_i_n(rst_i_n), .data_in(meas_in),
        .data_vld(meas_vld), .setting(comp_eff), .data_out(scaled), .out_vld(scaled_vld),
        .apply(comp_kind));

    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            meas_out     <= 32'h0;
            meas_out_vld <= 1'b0;
        end else begin
            meas_out_vld <= scaled_vld;
            if (scaled_vld)
                meas_out <= smooth_r ? avg_sum[32:1] : scaled;
        end
    end

    // Display word and outputs
    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            disp_code    <= `CSC_D_MEAS;
            disp_val     <= 32'h0;
            disp_frac    <= 3'h0;
            comp_setting <= `CSC_COMP_DEF;
            prec_places  <= `CSC_PREC_DEF;
            smooth_on    <= `CSC_SMOOTH_DEF;
            exp_coef     <= `CSC_EXP_DEF;
        end else begin
            disp_code    <= disp_r;
            comp_setting <= comp_eff;
            prec_places  <= prec_r + {3'h0, imp};
            smooth_on    <= smooth_r;
            exp_coef     <= exp_r;
            disp_frac    <= 3'h0;
            case (disp_r)
                `CSC_D_MEAS: begin
                    disp_val  <= meas_out;
                    disp_frac <= prec_r[2:0] + {2'h0, imp};
                end
                `CSC_D_FACT: begin
                    disp_val  <= {18'h0, comp_eff};
                    disp_frac <= 3'h1;
                end
                `CSC_D_TEMP: begin
                    disp_val  <= {16'h0, a_t};
                    disp_frac <= 3'h2;
                end
                `CSC_D_PRES: begin
                    disp_val  <= {15'h0, a_p};
                    disp_frac <= 3'h2;
                end
                `CSC_D_HUM:   disp_val <= {24'h0, a_h};
                `CSC_D_SFLT:  disp_val <= {29'h0, flt};
                `CSC_D_PREC: begin
                    // Sign mirrors smoothing, as it is entered
                    if (smooth_r)
                        disp_val <= {28'h0, prec_r + {3'h0, imp}};
                    else
                        disp_val <= -{28'h0, prec_r + {3'h0, imp}};
                end
                `CSC_D_EXPC: begin
                    disp_val  <= {{16{exp_r[15]}}, exp_r};
                    disp_frac <= 3'h1;
                end
                `CSC_D_LIMIT: begin
                    disp_val  <= {{16{lim_r[15]}}, lim_r};
                    disp_frac <= (err_key_r == `CSC_KEY_PREC) ? 3'h0 : 3'h1;
                end
                default:      disp_val <= 32'h0;
            endcase
        end
    end
endmodule

//--- shared/csc_map.vh
`ifndef CSC_MAP_VH
`define CSC_MAP_VH
// Compensation setting, tenths of abcd
`define CSC_COMP_DEF   14'h1c78
`define CSC_COMP_MAX   16'h270f
`define CSC_COMP_ONE   16'h2710
`define CSC_K_BASE     24'h986f70
`define CSC_K_DEN      24'h989680
// Expansion coefficient, tenths of ppm
`define CSC_EXP_MAX    16'h1c20
`define CSC_EXP_MIN    16'he3e0
`define CSC_EXP_DEF    16'h0000
// Precision reset values
`define CSC_PREC_DEF   4'h3
`define CSC_SMOOTH_DEF 1'b1
// Standard air
`define CSC_T_STD      16'h07d0
`define CSC_P_STD      17'h128e0
`define CSC_H_STD      8'h32
// Sensor update interval
`define CSC_UPD_MS     3000
`define CSC_CLK_KHZ    100000
// Key identities
`define CSC_KEY_COMP   3'h0
`define CSC_KEY_PREC   3'h1
`define CSC_KEY_EXP    3'h2
// Measurement kinds
`define CSC_MK_DIST    2'h0
`define CSC_MK_VEL     2'h1
`define CSC_MK_ANG     2'h2
`define CSC_MK_STR     2'h3
// Display contents
`define CSC_D_MEAS     4'h0
`define CSC_D_FACT     4'h1
`define CSC_D_TEMP     4'h2
`define CSC_D_PRES     4'h3
`define CSC_D_HUM      4'h4
`define CSC_D_CERR     4'h5
`define CSC_D_SFLT     4'h6
`define CSC_D_PREC     4'h7
`define CSC_D_EXPC     4'h8
`define CSC_D_OVER     4'h9
`define CSC_D_UNDER    4'ha
`define CSC_D_LIMIT    4'hb
`endif

//--- design/csc_limit.v
`timescale 1ns/100ps
module csc_limit #(
    parameter W = 16
) (
    // Value and bounds
    input  wire signed [W-1:0] val,
    input  wire signed [W-1:0] lo,
    input  wire signed [W-1:0] hi,
    // Verdict
    output wire                too_big,
    output wire                too_small
);
    assign too_big   = (val > hi);
    assign too_small = (val < lo);
endmodule

//--- design/csc_scale.v
`timescale 1ns/100ps
`include "csc_map.vh"
module csc_scale (
    // Clock and reset
    input  wire               sys_clk,
    input  wire               rst_i_n,
    // Raw data
    input  wire signed [31:0] data_in,
    input  wire               data_vld,
    input  wire               apply,
    input  wire        [13:0] setting,
    // Scaled data
    output reg  signed [31:0] data_out,
    output reg                out_vld
);
    // Factor times ten million; 1000.0 lands on exactly one
    wire        [23:0] k    = `CSC_K_BASE + {10'h0, setting};
    wire signed [56:0] prod = data_in * $signed({1'b0, k});
    wire signed [56:0] quo  = prod / $signed({33'h0, `CSC_K_DEN});

    always @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            data_out <= 32'h0;
            out_vld  <= 1'b0;
        end else begin
            out_vld <= data_vld;
            if (data_vld) begin
                data_out <= apply ? quo[31:0] : data_in;
            end
        end
    end
endmodule

//--- verif/csc_air_model.sv
`timescale 1ns/100ps
module csc_air_model (
    // Clock
    input  wire          sys_clk,
    // Scenario controls
    input  wire          connect,
    input  wire [2:0]    fault_cmd,
    input  wire [15:0]   t_set,
    input  wire [16:0]   p_set,
    input  wire [7:0]    h_set,
    // Sensor pins
    output logic         sens_present,
    output logic [2:0]   sens_fault,
    output logic [15:0]  air_temp,
    output logic [16:0]  air_pres,
    output logic [7:0]   air_hum
);
    logic [7:0] wig = 8'h00;
    always @(posedge sys_clk) begin
        wig <= wig + 8'h01;
    end
    // Unplugged: readings churn so stale values can never look valid
    always @* begin
        sens_present = connect;
        sens_fault   = connect ? fault_cmd : 3'h0;
        air_temp     = connect ? t_set : {wig, ~wig};
        air_pres     = connect ? p_set : {1'b0, ~wig, wig};
        air_hum      = connect ? h_set : ~wig;
    end
endmodule

//--- verif/csc_top_asserts.sv
`timescale 1ns/100ps
module csc_top_asserts (
    // Clock and reset
    input wire               sys_clk,
    input wire               rst_n,
    // Inputs
    input wire               key_evt,
    input wire        [2:0]  key_id,
    input wire               entry_vld,
    input wire signed [15:0] entry_val,
    input wire               hi_err,
    input wire        [1:0]  meas_kind,
    input wire signed [31:0] meas_in,
    input wire               meas_vld,
    input wire               sens_present,
    input wire        [2:0]  sens_fault,
    // Outputs
    input wire signed [31:0] meas_out,
    input wire               meas_out_vld,
    input wire               smooth_on,
    input wire        [3:0]  disp_code,
    input wire        [2:0]  disp_frac,
    input wire        [13:0] comp_setting,
    input wire signed [15:0] exp_coef
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_setting_range: assert property (
        comp_setting <= 14'h2710) else $error("setting out of range");
    chk_exp_range: assert property (
        exp_coef <= 16'sh1c20 && exp_coef >= -16'sh1c20) else $error("coefficient out of range");
    chk_factor_format: assert property (
        disp_code == 4'h1 |-> disp_frac == 3'h1) else $error("factor digits wrong");
    chk_meas_latency: assert property (
        meas_out_vld == $past(meas_vld, 2)) else $error("output strobe misplaced");
    chk_angle_pass: assert property (
        meas_vld && meas_kind == 2'h2 && !smooth_on
        |-> ##2 meas_out == $past(meas_in, 2)) else $error("angle was scaled");
    chk_prec_view: assert property (
        key_evt && key_id == 3'h1 && !entry_vld && disp_code == 4'h0 && !$past(key_evt)
        |-> ##2 disp_code == 4'h7) else $error("precision not shown");
    chk_exp_view: assert property (
        key_evt && key_id == 3'h2 && !entry_vld && disp_code == 4'h0 && !$past(key_evt)
        |-> ##2 (disp_code == 4'h8 && disp_frac == 3'h1)) else $error("coefficient not shown");
    chk_entry_error: assert property (
        key_evt && key_id == 3'h0 && entry_vld && !sens_present
        && (entry_val > 16'sh2710 || entry_val < 16'sh0000)
        |-> ##2 disp_code == ($past(entry_val, 2) < 16'sh0000 ? 4'ha : 4'h9)
        ) else $error("range message missing");
    chk_unity_entry: assert property (
        key_evt && key_id == 3'h0 && entry_vld && entry_val == 16'sh2710 && !sens_present
        |-> ##2 comp_setting == 14'h2710) else $error("unity setting refused");
    chk_fault_shown: assert property (
        $rose(sens_fault[2]) && sens_present && !hi_err && !key_evt
        |-> ##[1:6] disp_code == 4'h6) else $error("sensor fault not shown");
endmodule
bind csc_top csc_top_asserts chk (.sys_clk, .rst_n, .key_evt, .key_id, .entry_vld, .entry_val,
    .hi_err, .meas_kind, .meas_in, .meas_vld, .sens_present, .sens_fault, .meas_out,
    .meas_out_vld, .disp_code, .disp_frac, .comp_setting, .exp_coef, .smooth_on);

//--- verif/csc_top_tb_top.sv
`timescale 1ns/100ps
module csc_top_tb_top;
    logic sys_clk = 0, rst_n = 0, key_evt = 0, entry_vld = 0, hi_err = 0;
    logic meas_vld = 0, unit_imp = 0, conn = 0;
    logic        [2:0]  key_id = 0, flt = 0;
    logic signed [15:0] entry_val = 0;
    logic        [1:0]  meas_kind = 0;
    logic signed [31:0] meas_in = 0;
    logic        [15:0] t_set = 16'h07d0;
    logic        [16:0] p_set = 17'h128e0;
    logic        [7:0]  h_set = 8'h32;
    wire sens_present, meas_out_vld, smooth_on;
    wire         [2:0]  sens_fault, disp_frac;
    wire         [15:0] air_temp;
    wire         [16:0] air_pres;
    wire         [7:0]  air_hum;
    wire signed  [31:0] meas_out, disp_val;
    wire         [3:0]  disp_code, prec_places;
    wire         [13:0] comp_setting;
    wire signed  [15:0] exp_coef;
    int err_total = 0, comparisons = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    // Short update interval keeps sensor scenarios brief
    csc_top #(.UPD_CYC(50)) uut (.sys_clk, .rst_n, .key_evt, .key_id, .entry_vld, .entry_val,
        .hi_err, .meas_kind, .meas_in, .meas_vld, .meas_out, .meas_out_vld, .sens_present,
        .sens_fault, .air_temp, .air_pres, .air_hum, .unit_imp, .disp_code, .disp_val,
        .disp_frac, .comp_setting, .prec_places, .smooth_on, .exp_coef);
    csc_air_model air (.sys_clk, .connect(conn), .fault_cmd(flt), .t_set, .p_set, .h_set,
        .sens_present, .sens_fault, .air_temp, .air_pres, .air_hum);
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            $display("timeout reached");
            print_verdict;
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // One-cycle key pulse with its id and entry
    task automatic press(input logic [2:0] id, input logic ev, input logic signed [15:0] v);
        @(negedge sys_clk);
        key_evt = 1;
        key_id = id;
        entry_vld = ev;
        entry_val = v;
        @(negedge sys_clk);
        key_evt = 0;
        entry_vld = 0;
        cyc_n(2);
    endtask
    task automatic kv(input logic [2:0] id, input logic ev, input logic signed [15:0] v,
                      input logic [3:0] c);
        press(id, ev, v);
        check("disp_code", disp_code, c);
    endtask
    task automatic meas(input logic [1:0] k, input logic signed [31:0] v,
                        input logic signed [31:0] e);
        @(negedge sys_clk);
        meas_kind = k;
        meas_in = v;
        meas_vld = 1;
        @(negedge sys_clk);
        meas_vld = 0;
        cyc_n(1);
        check("meas_out_vld", meas_out_vld, 1'b1);
        check("meas_out", meas_out, e);
    endtask
    task automatic t_reset;
        check("comp_setting", comp_setting, 14'h1c78);
        check("exp_coef", exp_coef, 16'h0000);
        check("disp_code", disp_code, 4'h0);
        $display("reset test done");
    endtask
    task automatic t_comp;
        kv(3'h0, 0, 0, 4'h1);
        check("factor", disp_val, 32'h1c78);
        check("frac", disp_frac, 3'h1);
        kv(3'h0, 0, 0, 4'h0);
        kv(3'h0, 1, 16'sh1388, 4'h1);
        check("comp_setting", comp_setting, 14'h1388);
        kv(3'h0, 1, 16'sh2710, 4'h1);
        kv(3'h0, 1, 16'sh2711, 4'h9);
        kv(3'h0, 0, 0, 4'hb);
        check("limit", disp_val, 32'h270f);
        kv(3'h0, 0, 0, 4'h1);
        check("comp_setting", comp_setting, 14'h270f);
        kv(3'h0, 1, -16'sh0001, 4'ha);
        kv(3'h0, 0, 0, 4'hb);
        check("limit", disp_val, 32'h0);
        kv(3'h0, 1, 16'sh0000, 4'h1);
        check("comp_setting", comp_setting, 14'h0000);
        $display("compensation test done");
    endtask
    task automatic t_meas;
        press(3'h1, 1, -16'sh0003);
        check("smooth_on", smooth_on, 1'b0);
        check("prec_places", prec_places, 4'h3);
        meas(2'h0, 32'sh00989680, 32'sh00986f70);
        meas(2'h1, -32'sh00989680, -32'sh00986f70);
        meas(2'h2, 32'sh00003039, 32'sh00003039);
        press(3'h1, 1, 16'sh0002);
        check("smooth_on", smooth_on, 1'b1);
        unit_imp = 1;
        cyc_n(6);
        check("prec_places", prec_places, 4'h3);
        check("smooth_on", smooth_on, 1'b1);
        unit_imp = 0;
        kv(3'h1, 0, 0, 4'h0);
        $display("measurement test done");
    endtask
    task automatic t_view;
        kv(3'h1, 0, 0, 4'h7);
        check("places", disp_val, 32'h2);
        kv(3'h1, 0, 0, 4'h0);
        kv(3'h2, 0, 0, 4'h8);
        check("coef", disp_val, 32'h0);
        kv(3'h2, 0, 0, 4'h0);
        kv(3'h2, 1, 16'sh1c20, 4'h8);
        kv(3'h2, 1, 16'sh1c21, 4'h9);
        kv(3'h2, 1, -16'sh1c21, 4'ha);
        kv(3'h2, 1, -16'sh1c20, 4'h8);
        check("exp_coef", exp_coef, 32'hffffe3e0);
        kv(3'h7, 0, 0, 4'h0);
        $display("view test done");
    endtask
    task automatic t_sensor;
        conn = 1;
        cyc_n(60);
        check("comp_setting", comp_setting, 14'h1c78);
        press(3'h0, 1, 16'sh1388);
        check("comp_setting", comp_setting, 14'h1c78);
        t_set = 16'h0834;
        cyc_n(60);
        check("comp_setting", comp_setting, 14'h1cd5);
        kv(3'h7, 0, 0, 4'h0);
        kv(3'h0, 0, 0, 4'h1);
        kv(3'h0, 0, 0, 4'h2);
        check("temp", disp_val, 32'h834);
        kv(3'h0, 0, 0, 4'h3);
        kv(3'h7, 0, 0, 4'h0);
        kv(3'h0, 0, 0, 4'h3);
        kv(3'h0, 0, 0, 4'h4);
        kv(3'h0, 0, 0, 4'h0);
        flt = 3'h4;
        cyc_n(6);
        check("disp_code", disp_code, 4'h6);
        kv(3'h0, 0, 0, 4'h5);
        kv(3'h0, 0, 0, 4'h2);
        kv(3'h0, 0, 0, 4'h3);
        kv(3'h0, 0, 0, 4'h0);
        hi_err = 1;
        flt = 3'h6;
        cyc_n(6);
        check("disp_code", disp_code, 4'h0);
        hi_err = 0;
        flt = 3'h0;
        conn = 0;
        cyc_n(6);
        $display("sensor test done");
    endtask
    initial begin
        cyc_n(10);
        rst_n = 1;
        cyc_n(5);
        t_reset;
        t_comp;
        t_meas;
        t_view;
        t_sensor;
        print_verdict;
    end
endmodule
